// ==== dv/itc_timer_tb_top.sv ====
module itc_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic               sys_clk = 1'b0;
   logic               rst = 1'b1;
   logic               gate_q = 1'b1;
   logic               pol_q = 1'b1;
   logic               rd_q = 1'b0;
   logic               wrw_q = 1'b0;
   logic               wrs_q = 1'b0;
   itc_pkg::itc_word_t data_q = 64'h0;
   itc_pkg::itc_word_t rd_data;
   logic               rd_valid;
   logic               irq;
   itc_pkg::itc_word_t got;
   int                 n_fail = 0;
   int                 cmp_count = 0;

   // 200 MHz system clock
   always #2.5 sys_clk = ~sys_clk;

   itc_timer itc_timer_i (
      .sys_clk(sys_clk), .rst(rst), .timer_gate_flag(gate_q),
      .gate_polarity(pol_q), .rd_word(rd_q), .wr_word(wrw_q),
      .wr_status(wrs_q), .scalar_register(data_q), .rd_data_q(rd_data),
      .rd_valid_q(rd_valid), .irq_q(irq));

   // Expected word; the unused bits are always zero
   function automatic itc_pkg::itc_word_t w(logic r, logic e, logic [1:0] s,
                                            logic [19:0] rl, logic [19:0] c);
      return {r, e, s[0], s[1], rl, 12'h000, c, 8'h00};
   endfunction

   task automatic chk(string nm, itc_pkg::itc_word_t g, itc_pkg::itc_word_t e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cyc(int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Read strobe for one cycle; answer is looked at in its only cycle
   task automatic rd();
      @(posedge sys_clk) rd_q <= 1'b1;
      @(posedge sys_clk) rd_q <= 1'b0;
      #1;
      chk("rd_valid", 64'(rd_valid), 64'h1);
      got = rd_data;
   endtask

   task automatic wr(logic ws, itc_pkg::itc_word_t d);
      @(posedge sys_clk) begin
         wrw_q <= ~ws;
         wrs_q <= ws;
         data_q <= d;
      end
      @(posedge sys_clk) begin
         wrw_q <= 1'b0;
         wrs_q <= 1'b0;
      end
   endtask

   // Bounded wait, a hang ends the run as a mismatch
   task automatic wirq();
      int i;
      for (i = 0; i < 1000 && irq !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      if (i == 1000) begin
         chk("irq_wait", 64'(irq), 64'h1);
         complete_run();
      end
   endtask

   task automatic t_reset();
      rd();
      chk("reset_word", got, 64'h0);
      $display("t_reset done");
   endtask

   // Unused bits written as ones, decrement on empty count stores nothing
   task automatic t_fields();
      wr(1'b0, 64'h6abcdefff12345ff);
      rd();
      chk("word_fields", got, w(0, 1, 2'b00, 20'habcde, 20'h12345));
      chk("irq_idle", 64'(irq), 64'h0);
      $display("t_fields done");
   endtask

   // Reload of all ones gives a terminal count on every tick
   task automatic t_count();
      wr(1'b0, w(1, 1, 2'b00, 20'hfffff, 20'hfffff));
      wirq();
      cyc(700);
      wr(1'b1, 64'h4000000000000000);
      rd();
      chk("status_sat", got, w(0, 1, 2'b11, 20'hfffff, 20'hfffff));
      cyc(400);
      rd();
      chk("hold_stopped", got, w(0, 1, 2'b11, 20'hfffff, 20'hfffff));
      $display("t_count done");
   endtask

   task automatic t_dec();
      logic [1:0] st [3] = '{2'b01, 2'b00, 2'b00};
      for (int k = 0; k < 3; k++) begin
         wr(1'b1, 64'h6000000000000000);
         rd();
         chk("dec_step", got, w(0, 1, st[k], 20'hfffff, 20'hfffff));
         chk("irq_level", 64'(irq), 64'(st[k][0]));
      end
      $display("t_dec done");
   endtask

   // Gate closed holds the count; opened by the other sense it counts
   task automatic t_gate();
      @(posedge sys_clk) gate_q <= 1'b0;
      wr(1'b0, w(1, 0, 2'b00, 20'h0, 20'h00010));
      cyc(450);
      rd();
      chk("gate_off", got, w(1, 0, 2'b00, 20'h0, 20'h00010));
      @(posedge sys_clk) pol_q <= 1'b0;
      cyc(450);
      rd();
      chk("tick_rate", 64'(got[27:8] > 20'h11 && got[27:8] < 20'h14),
          64'h1);
      $display("t_gate done");
   endtask

   // Reset in mid-run clears status, count, reload and the interrupt
   task automatic t_rerst();
      wr(1'b0, w(1, 1, 2'b00, 20'h00abc, 20'hfffff));
      wirq();
      @(posedge sys_clk) rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      rd();
      chk("rerst_word", got, 64'h0);
      chk("rerst_irq", 64'(irq), 64'h0);
      $display("t_rerst done");
   endtask

   initial begin
      cyc(2);
      rst <= 1'b0;
      t_reset();
      t_fields();
      t_count();
      t_dec();
      t_gate();
      t_rerst();
      complete_run();
   end
endmodule

// ==== rtl/itc_params.svh ====
`ifndef ITC_PARAMS_SVH
`define ITC_PARAMS_SVH

// Timer word field positions
`define ITC_RUN_BIT       63
`define ITC_IEN_BIT       62
`define ITC_FULL_BIT      61
`define ITC_OVF_BIT       60
`define ITC_RLD_HI        59
`define ITC_RLD_LO        40
`define ITC_CNT_HI        27
`define ITC_CNT_LO        8

// Reset values
`define ITC_CNT_RST       20'h00000
`define ITC_RLD_RST       20'h00000
`define ITC_STAT_RST      4'h0

// Timing: 200 MHz system clock, 2 MHz reference, 1 us tick
`define ITC_SYS_MHZ       200
`define ITC_REF_MHZ       2
`define ITC_REF_DIV       (`ITC_SYS_MHZ / `ITC_REF_MHZ)

`endif

// ==== rtl/itc_pkg.sv ====
package itc_pkg;
   typedef logic [19:0] itc_cnt_t;
   typedef logic [63:0] itc_word_t;
   // Two-bit pseudocounter: overflow, full
   typedef enum logic [1:0] {
      ITC_ST_EMPTY = 2'b00,
      ITC_ST_ONE   = 2'b01,
      ITC_ST_BOTH  = 2'b11
   } itc_stat_t;
endpackage

// ==== rtl/itc_tick_gen.sv ====
`include "itc_params.svh"

// Halves the 2 MHz reference into a one-cycle 1 us tick
module itc_tick_gen (
   input  wire logic sys_clk,
   input  wire logic rst,
   output logic      tick_q
);
   logic [6:0] div_q;
   logic       half_q;

   // Reference divider: one pulse every 0.5 us
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_q  <= 7'h00;
         half_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (div_q == 7'(`ITC_REF_DIV - 1)) begin
            div_q  <= 7'h00;
            half_q <= ~half_q;
            tick_q <= half_q; // Every second reference edge
         end else begin
            div_q <= div_q + 7'h01;
         end
      end
   end
endmodule

// ==== rtl/itc_timer.sv ====
`include "itc_params.svh"

// Behaviour
// - The count rises by one each microsecond tick while running.
// - At the maximum count the next tick wraps it to zero; the clock after that reloads and records an event.
// - The count sits in bits 27..8 and wraps at terminal count.
// - The reload value sits in bits 59..40 and is never changed by a reload.
// - Bit 63 is run; the count holds while it is clear.
// - Bit 62 enables an interrupt whenever full is set.
// - Bit 61 reads as full and on writes is a decrement command.
// - Overflow and full form a two-bit count stepping 00, 01, 11, 11.
// - A write with bit 61 set steps the count 11 to 01 to 00.
// - Delivering an interrupt leaves full and overflow unchanged.
// - A read copies the whole 64-bit word at once.
// - A word write loads count, reload, run and enable together.
// - A status write changes only the top four status bits.
// - Bits 39..28 and 7..0 read zero and ignore writes.
// - An external gate flag enables the timer by its polarity.
module itc_timer (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic                timer_gate_flag,
   input  wire logic                gate_polarity,
   input  wire logic                rd_word,
   input  wire logic                wr_word,
   input  wire logic                wr_status,
   input  wire itc_pkg::itc_word_t  scalar_register,
   output itc_pkg::itc_word_t       rd_data_q,
   output logic                     rd_valid_q,
   output logic                     irq_q
);
   itc_pkg::itc_cnt_t  cnt_q;
   itc_pkg::itc_cnt_t  rld_q;
   logic               run_q;
   logic               ien_q;
   itc_pkg::itc_stat_t st_q;
   itc_pkg::itc_stat_t st_d;
   logic               tick;
   logic               tc_pend_q;
   logic               gate_on;
   logic               any_wr;
   logic               dec_cmd;
   logic               tc_evt;

   itc_tick_gen u_tick (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tick_q  (tick)
   );

   assign gate_on = (timer_gate_flag == gate_polarity);
   assign any_wr  = wr_word | wr_status;
   // bit 61 write is a command
   assign dec_cmd = any_wr & scalar_register[`ITC_FULL_BIT];
   assign tc_evt  = tc_pend_q;

   // Assembled word; reserved bits stay zero
   function automatic itc_pkg::itc_word_t pack_word(
      input logic r, input logic e, input itc_pkg::itc_stat_t s,
      input itc_pkg::itc_cnt_t rl, input itc_pkg::itc_cnt_t c);
      itc_pkg::itc_word_t w;
      w = 64'h0;
      w[`ITC_RUN_BIT]  = r;
      w[`ITC_IEN_BIT]  = e;
      w[`ITC_FULL_BIT] = s[0];
      w[`ITC_OVF_BIT]  = s[1];
      w[`ITC_RLD_HI:`ITC_RLD_LO] = rl;
      w[`ITC_CNT_HI:`ITC_CNT_LO] = c;
      return w;
   endfunction

   // Status pseudocounter next value; a terminal count and a decrement
   // in the same cycle cancel, so no event is lost unless the count is empty
   always_comb begin
      st_d = st_q;
      if (tc_evt && !dec_cmd) begin
         st_d = (st_q == itc_pkg::ITC_ST_EMPTY) ? itc_pkg::ITC_ST_ONE
                                                 : itc_pkg::ITC_ST_BOTH;
      end else if (dec_cmd && !tc_evt) begin
         st_d = (st_q == itc_pkg::ITC_ST_BOTH) ? itc_pkg::ITC_ST_ONE
                                                : itc_pkg::ITC_ST_EMPTY;
      end
   end

   // Status register; interrupt delivery has no effect here
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= itc_pkg::ITC_ST_EMPTY;
      end else begin
         st_q <= st_d;
      end
   end

   // Run and enable bits, written by both write forms
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         run_q <= 1'b0;
         ien_q <= 1'b0;
      // status write touches top bits only
      end else if (any_wr) begin
         run_q <= scalar_register[`ITC_RUN_BIT];
         ien_q <= scalar_register[`ITC_IEN_BIT];
      end
   end

   // Reload value; only a whole-word write changes it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rld_q <= `ITC_RLD_RST;
      end else if (wr_word) begin
         rld_q <= scalar_register[`ITC_RLD_HI:`ITC_RLD_LO];
      end
   end

   // Counter; writes win over counting
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_q     <= `ITC_CNT_RST;
         tc_pend_q <= 1'b0;
      end else begin
         tc_pend_q <= 1'b0;
         if (wr_word) begin
            cnt_q <= scalar_register[`ITC_CNT_HI:`ITC_CNT_LO];
         // reload on the clock after the wrap to zero
         end else if (tc_pend_q) begin
            cnt_q <= rld_q;
         end else if (run_q && gate_on && tick) begin
            cnt_q <= cnt_q + 20'h00001;
            // wrap to zero is a terminal count
            tc_pend_q <= (cnt_q == 20'hfffff);
         end
      end
   end

   // Read port; whole word in one cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_data_q  <= 64'h0;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_word;
         if (rd_word) begin
            rd_data_q <= pack_word(run_q, ien_q, st_q, rld_q, cnt_q);
         end
      end
   end

   // Interrupt level
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= ien_q & st_q[0];
      end
   end

   // Terminal count steps the status up one cycle later
   property p_tc_up;
      @(posedge sys_clk) disable iff (rst)
      (tc_pend_q && !dec_cmd && st_q == itc_pkg::ITC_ST_EMPTY)
         |=> st_q == itc_pkg::ITC_ST_ONE;
   endproperty
   a_tc_up: assert property (p_tc_up)
      else $error("status not stepped up");

   property p_dec;
      @(posedge sys_clk) disable iff (rst)
      (dec_cmd && !tc_pend_q && st_q == itc_pkg::ITC_ST_BOTH)
         |=> st_q == itc_pkg::ITC_ST_ONE;
   endproperty
   a_dec: assert property (p_dec)
      else $error("status not stepped down");

   property p_hold;
      @(posedge sys_clk) disable iff (rst)
      (!run_q && !wr_word && !tc_pend_q) |=> cnt_q == $past(cnt_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("count moved while stopped");

   property p_reload;
      @(posedge sys_clk) disable iff (rst)
      (tc_pend_q && !wr_word) |=> cnt_q == $past(rld_q);
   endproperty
   a_reload: assert property (p_reload)
      else $error("reload missed");

   property p_rld_keep;
      @(posedge sys_clk) disable iff (rst)
      !wr_word |=> rld_q == $past(rld_q);
   endproperty
   a_rld_keep: assert property (p_rld_keep)
      else $error("reload changed");

   property p_irq;
      @(posedge sys_clk) disable iff (rst)
      ##1 irq_q == $past(ien_q & st_q[0]);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt level wrong");

   property p_stat_only;
      @(posedge sys_clk) disable iff (rst)
      (wr_status && !wr_word && !tc_pend_q && !(run_q && tick))
         |=> cnt_q == $past(cnt_q) && rld_q == $past(rld_q);
   endproperty
   a_stat_only: assert property (p_stat_only)
      else $error("status write leaked");

   property p_resv;
      @(posedge sys_clk) disable iff (rst)
      rd_valid_q |-> rd_data_q[39:28] == 12'h000 && rd_data_q[7:0] == 8'h00;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved bits nonzero");

   property p_step;
      @(posedge sys_clk) disable iff (rst)
      (run_q && gate_on && tick && !wr_word && !tc_pend_q)
         |=> cnt_q == $past(cnt_q) + 20'h00001;
   endproperty
   a_step: assert property (p_step)
      else $error("count did not step");

   // Cycles since the last tick; all ones until the first one after reset
   logic [7:0] gap_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gap_q <= 8'hff;
      end else if (tick) begin
         gap_q <= 8'h00;
      end else if (gap_q != 8'hff) begin
         gap_q <= gap_q + 8'h01;
      end
   end

   // Ticks are one microsecond apart once the divider has run a lap
   property p_rate;
      @(posedge sys_clk) disable iff (rst)
      (tick && gap_q != 8'hff) |-> gap_q == 8'(2 * `ITC_REF_DIV - 1);
   endproperty
   a_rate: assert property (p_rate)
      else $error("tick spacing wrong");

   // Wrap step: a tick while running at the top of the count
   sequence s_top_tick;
      run_q && gate_on && tick && !wr_word && !tc_pend_q
         && cnt_q == 20'hfffff;
   endsequence

   sequence s_wrapped;
      cnt_q == 20'h00000 && tc_pend_q;
   endsequence

   property p_wrap;
      @(posedge sys_clk) disable iff (rst)
      s_top_tick |=> s_wrapped;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("wrap to zero missed");

   // A terminal count on a non-empty count saturates at both bits set
   property p_sat;
      @(posedge sys_clk) disable iff (rst)
      (tc_pend_q && !dec_cmd && st_q != itc_pkg::ITC_ST_EMPTY)
         |=> st_q == itc_pkg::ITC_ST_BOTH;
   endproperty
   a_sat: assert property (p_sat)
      else $error("status did not saturate");

   // A decrement below both bits lands on empty and stays there
   property p_floor;
      @(posedge sys_clk) disable iff (rst)
      (dec_cmd && !tc_pend_q && st_q != itc_pkg::ITC_ST_BOTH)
         |=> st_q == itc_pkg::ITC_ST_EMPTY;
   endproperty
   a_floor: assert property (p_floor)
      else $error("status went below empty");

   // Without exactly one of the two events the status stands still
   property p_keep;
      @(posedge sys_clk) disable iff (rst)
      (tc_pend_q == dec_cmd) |=> $stable(st_q);
   endproperty
   a_keep: assert property (p_keep)
      else $error("status moved without cause");

   // Both write forms load run and enable from the top two bits
   property p_ctrl;
      @(posedge sys_clk) disable iff (rst)
      any_wr |=> run_q == $past(scalar_register[`ITC_RUN_BIT])
         && ien_q == $past(scalar_register[`ITC_IEN_BIT]);
   endproperty
   a_ctrl: assert property (p_ctrl)
      else $error("control bits not loaded");

   // Status bits read back as run, enable, full and overflow
   property p_rd_stat;
      @(posedge sys_clk) disable iff (rst)
      rd_word |=> rd_data_q[`ITC_RUN_BIT:`ITC_OVF_BIT]
         == $past({run_q, ien_q, st_q[0], st_q[1]});
   endproperty
   a_rd_stat: assert property (p_rd_stat)
      else $error("status read back wrong");

   // Every read is answered on the next clock
   property p_rd_ans;
      @(posedge sys_clk) disable iff (rst)
      rd_word |=> rd_valid_q;
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read not answered");

   // A closed gate freezes the count like a cleared run bit
   property p_gate;
      @(posedge sys_clk) disable iff (rst)
      (!gate_on && !wr_word && !tc_pend_q) |=> $stable(cnt_q);
   endproperty
   a_gate: assert property (p_gate)
      else $error("count moved with gate closed");
endmodule
